/* File: inc/clock_divider_pkg.sv */
/*
 * Constants for the output-pair clock divider block: register indices,
 * bit positions, reset values and bus widths.
 * Assumes an APB bus with 32-bit data and one register per aligned word.
 */
package clock_divider_pkg;

   // ==========================================================================
   // Bus
   // ==========================================================================
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W  = 8;
   localparam int IDX_W  = 10;

   // ==========================================================================
   // Register indices; byte address is four times the index
   // ==========================================================================
   localparam logic [IDX_W-1:0] IDX_B_COUNTS  = 10'h193;
   localparam logic [IDX_W-1:0] IDX_B_CONTROL = 10'h194;
   localparam logic [IDX_W-1:0] IDX_B_ROUTE   = 10'h195;
   localparam logic [IDX_W-1:0] IDX_C_COUNTS  = 10'h196;
   localparam logic [IDX_W-1:0] IDX_C_CONTROL = 10'h197;
   localparam logic [IDX_W-1:0] IDX_C_ROUTE   = 10'h198;
   localparam logic [IDX_W-1:0] IDX_CLK_INPUT = 10'h1E1;
   localparam logic [IDX_W-1:0] IDX_STATUS    = 10'h1F0;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int LOW_MSB     = 7;
   localparam int LOW_LSB     = 4;
   localparam int HIGH_MSB    = 3;
   localparam int HIGH_LSB    = 0;
   localparam int BIT_BYPASS  = 7;
   localparam int BIT_NOSYNC  = 6;
   localparam int BIT_FORCE   = 5;
   localparam int BIT_START   = 4;
   localparam int PHASE_MSB   = 3;
   localparam int PHASE_LSB   = 0;
   localparam int BIT_DIRECT  = 1;
   localparam int BIT_DCC_OFF = 0;
   localparam int BIT_SEL_OSC = 1;
   localparam int BIT_NO_PRE  = 0;

   // ==========================================================================
   // Reset values and codes
   // ==========================================================================
   localparam logic [REG_W-1:0] RST_COUNTS  = 8'h00;
   localparam logic [REG_W-1:0] RST_CONTROL = 8'h00;
   localparam logic [REG_W-1:0] RST_ROUTE   = 8'h00;
   localparam logic [REG_W-1:0] RST_CLK_IN  = 8'h00;
   localparam logic [1:0]       ROUTE_MASK  = 2'h3;
   localparam logic [1:0]       SEL_EXT     = 2'h0;
   localparam logic [1:0]       SEL_EXT_NOP = 2'h1;
   localparam logic [1:0]       SEL_OSC     = 2'h2;

   typedef enum logic [1:0] {st_hold, st_offset, st_run} chan_state_t;

endpackage

/* File: rtl/output_pair_clock_divider.sv */
/*
 * Two programmable channel dividers (channels b and c) driving two output
 * pairs, with sync hold, phase offset, start level, forced level, bypass,
 * duty-cycle correction and direct routing, configured over APB.
 * Assumes osc_level, ext_level and sync_n are synchronous to pclk; the
 * divider counts both edges of its selected input level.
 */
//
// How it works
// - Low phase lasts low-count plus one input cycles with duty correction off; counts reset zero.
// - High phase lasts high-count plus one input cycles with duty correction off.
// - Bypass passes the divider input straight to the divider output.
// - Force-level bit picks the static level; zero is low.
// - Start-level bit picks the level the clock starts at after sync.
// - Each channel has a 4-bit phase offset resetting to zero.
// - Direct-route clear drives pair b from its divider.
// - Direct-route set with select 10 drives the pair from the oscillator.
// - Direct-route set with select 00 drives the pair from the external clock.
// - Direct-route set with select 01 has no effect.
// - Second channel routes its own pair the same way.
// - Second channel has identical force, start, offset, duty controls.
// - Clock-input bit 1 selects oscillator, zero the external clock.
// - Clock-input bit 0 bypasses the prescaler only when the external clock is selected.
// - Sync low holds obeying channels static; release synchronises them.
`timescale 1ns/1ps

module output_pair_clock_divider (
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [clock_divider_pkg::ADDR_W-1:0] paddr,
   input  wire logic [clock_divider_pkg::DATA_W-1:0] pwdata,
   input  wire logic [3:0]                          pstrb,
   output logic      [clock_divider_pkg::DATA_W-1:0] prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   input  wire logic                                osc_level,
   input  wire logic                                ext_level,
   input  wire logic                                sync_n,
   output logic                                     pair_b_pin_p,
   output logic                                     pair_b_pin_n,
   output logic                                     pair_c_pin_p,
   output logic                                     pair_c_pin_n
);

   // =========================================================================
   // Declarations
   // =========================================================================
   logic [clock_divider_pkg::REG_W-1:0] counts  [2];
   logic [clock_divider_pkg::REG_W-1:0] control [2];
   logic [clock_divider_pkg::REG_W-1:0] route   [2];
   logic [clock_divider_pkg::REG_W-1:0] clk_input;
   clock_divider_pkg::chan_state_t      state   [2];
   logic [5:0]                          cnt     [2];
   logic                                level   [2];
   logic                                chan_out[2];
   logic                                pair_lvl[2];
   logic                                hold    [2];
   logic [clock_divider_pkg::IDX_W-1:0] idx;
   logic                                mapped;
   logic                                wr_en;
   logic [clock_divider_pkg::REG_W-1:0] rd_val;
   logic                                pre_q;
   logic                                pre_div;
   logic                                src_q;
   logic                                div_in;
   logic                                div_in_q;
   logic                                in_edge;
   logic                                sync_active;

   // =========================================================================
   // Functions
   // =========================================================================
   function automatic logic is_mapped(input logic [clock_divider_pkg::IDX_W-1:0] i);
      is_mapped = (i == clock_divider_pkg::IDX_B_COUNTS)  ||
                  (i == clock_divider_pkg::IDX_B_CONTROL) ||
                  (i == clock_divider_pkg::IDX_B_ROUTE)   ||
                  (i == clock_divider_pkg::IDX_C_COUNTS)  ||
                  (i == clock_divider_pkg::IDX_C_CONTROL) ||
                  (i == clock_divider_pkg::IDX_C_ROUTE)   ||
                  (i == clock_divider_pkg::IDX_CLK_INPUT) ||
                  (i == clock_divider_pkg::IDX_STATUS);
   endfunction

   // Length of one phase in input half-cycles.
   function automatic logic [5:0] phase_len(input logic [7:0] cfg,
                                            input logic       dcc_off,
                                            input logic       high);
      logic [5:0] lo;
      logic [5:0] hi;
      lo = {2'h0, cfg[clock_divider_pkg::LOW_MSB:clock_divider_pkg::LOW_LSB]} + 6'h01;
      hi = {2'h0, cfg[clock_divider_pkg::HIGH_MSB:clock_divider_pkg::HIGH_LSB]} + 6'h01;
      if (!dcc_off) begin
         phase_len = lo + hi;
      end else if (high) begin
         phase_len = {hi[4:0], 1'b0};
      end else begin
         phase_len = {lo[4:0], 1'b0};
      end
   endfunction

   // Channel index 0 is register pair b and index 1 is register pair c.
   function automatic logic [1:0] route_sel(input logic [7:0] rt,
                                            input logic [7:0] ci);
      route_sel = rt[clock_divider_pkg::BIT_DIRECT] ? (ci[1:0] & clock_divider_pkg::ROUTE_MASK)
                                                    : clock_divider_pkg::SEL_EXT_NOP;
   endfunction

   // =========================================================================
   // APB slave
   // =========================================================================
   assign idx     = paddr[clock_divider_pkg::ADDR_W-1:2];
   assign mapped  = is_mapped(idx) && (paddr[1:0] == 2'h0);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign wr_en   = psel && penable && pwrite && mapped && pstrb[0];

   always_comb begin
      rd_val = 8'h00;
      case (idx)
         clock_divider_pkg::IDX_B_COUNTS:  rd_val = counts[0];
         clock_divider_pkg::IDX_B_CONTROL: rd_val = control[0];
         clock_divider_pkg::IDX_B_ROUTE:   rd_val = {6'h00, route[0][1:0]};
         clock_divider_pkg::IDX_C_COUNTS:  rd_val = counts[1];
         clock_divider_pkg::IDX_C_CONTROL: rd_val = control[1];
         clock_divider_pkg::IDX_C_ROUTE:   rd_val = {6'h00, route[1][1:0]};
         clock_divider_pkg::IDX_CLK_INPUT: rd_val = {6'h00, clk_input[1:0]};
         clock_divider_pkg::IDX_STATUS:
            rd_val = {1'b0, sync_active, pair_lvl[1], pair_lvl[0],
                      (state[1] == clock_divider_pkg::st_hold),
                      (state[0] == clock_divider_pkg::st_hold),
                      (state[1] == clock_divider_pkg::st_run),
                      (state[0] == clock_divider_pkg::st_run)};
         default: rd_val = 8'h00;
      endcase
   end

   // Read data is captured in the setup cycle and shown in the access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= mapped ? {24'h000000, rd_val} : 32'h00000000;
      end
   end

   // =========================================================================
   // Configuration registers
   // =========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < 2; c++) begin
            counts[c]  <= clock_divider_pkg::RST_COUNTS;
            control[c] <= clock_divider_pkg::RST_CONTROL;
            route[c]   <= clock_divider_pkg::RST_ROUTE;
         end
         clk_input <= clock_divider_pkg::RST_CLK_IN;
      end else if (wr_en) begin
         case (idx)
            clock_divider_pkg::IDX_B_COUNTS:  counts[0]  <= pwdata[7:0];
            clock_divider_pkg::IDX_B_CONTROL: control[0] <= pwdata[7:0];
            clock_divider_pkg::IDX_B_ROUTE:   route[0]   <= {6'h00, pwdata[1:0]};
            clock_divider_pkg::IDX_C_COUNTS:  counts[1]  <= pwdata[7:0];
            clock_divider_pkg::IDX_C_CONTROL: control[1] <= pwdata[7:0];
            clock_divider_pkg::IDX_C_ROUTE:   route[1]   <= {6'h00, pwdata[1:0]};
            clock_divider_pkg::IDX_CLK_INPUT: clk_input  <= {6'h00, pwdata[1:0]};
            default: ;
         endcase
      end
   end

   // =========================================================================
   // Divider input clock
   // =========================================================================
   // source select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q   <= 1'b0;
         pre_div <= 1'b0;
      end else begin
         src_q <= clk_input[clock_divider_pkg::BIT_SEL_OSC] ? osc_level : ext_level;
         if (clk_input[clock_divider_pkg::BIT_SEL_OSC] ? osc_level : ext_level) begin
            if (!src_q) begin
               pre_div <= !pre_div;
            end
         end
      end
   end

   assign pre_q  = pre_div;
   assign div_in = (clk_input[clock_divider_pkg::BIT_NO_PRE] &&
                    !clk_input[clock_divider_pkg::BIT_SEL_OSC]) ? src_q : pre_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_in_q <= 1'b0;
      end else begin
         div_in_q <= div_in;
      end
   end

   assign in_edge     = div_in ^ div_in_q;
   assign sync_active = !sync_n;

   // =========================================================================
   // Channel dividers
   // =========================================================================
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         hold[c] = sync_active && !control[c][clock_divider_pkg::BIT_NOSYNC];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < 2; c++) begin
            state[c] <= clock_divider_pkg::st_offset;
            cnt[c]   <= 6'h00;
            level[c] <= 1'b0;
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            case (state[c])
               clock_divider_pkg::st_hold: begin
                  cnt[c]   <= 6'h00;
                  level[c] <= control[c][clock_divider_pkg::BIT_FORCE];
                  if (!hold[c]) begin
                     state[c] <= clock_divider_pkg::st_offset;
                     level[c] <= control[c][clock_divider_pkg::BIT_START];
                  end
               end
               clock_divider_pkg::st_offset: begin
                  level[c] <= control[c][clock_divider_pkg::BIT_START];
                  if (hold[c]) begin
                     state[c] <= clock_divider_pkg::st_hold;
                  end else if ({1'b0, control[c][3:0], 1'b0} == 6'h00 ||
                               (in_edge && (cnt[c] + 6'h01 >= {1'b0, control[c][3:0], 1'b0}))) begin
                     state[c] <= clock_divider_pkg::st_run;
                     cnt[c]   <= 6'h00;
                  end else if (in_edge) begin
                     cnt[c] <= cnt[c] + 6'h01;
                  end
               end
               clock_divider_pkg::st_run: begin
                  if (hold[c]) begin
                     state[c] <= clock_divider_pkg::st_hold;
                  end else if (in_edge) begin
                     if (cnt[c] + 6'h01 >= phase_len(counts[c],
                           route[c][clock_divider_pkg::BIT_DCC_OFF], level[c])) begin
                        level[c] <= !level[c];
                        cnt[c]   <= 6'h00;
                     end else begin
                        cnt[c] <= cnt[c] + 6'h01;
                     end
                  end
               end
               default: state[c] <= clock_divider_pkg::st_hold;
            endcase
         end
      end
   end

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         if (control[c][clock_divider_pkg::BIT_BYPASS]) begin
            chan_out[c] = div_in;
         end else if (control[c][clock_divider_pkg::BIT_NOSYNC] &&
                      control[c][clock_divider_pkg::BIT_FORCE]) begin
            chan_out[c] = 1'b1;
         end else begin
            chan_out[c] = level[c];
         end
         case (route_sel(route[c], clk_input))
            clock_divider_pkg::SEL_OSC: pair_lvl[c] = osc_level;
            clock_divider_pkg::SEL_EXT: pair_lvl[c] = ext_level;
            default:                    pair_lvl[c] = chan_out[c];
         endcase
      end
   end

   // =========================================================================
   // Output pins
   // =========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pair_b_pin_p <= 1'b0;
         pair_b_pin_n <= 1'b1;
         pair_c_pin_p <= 1'b0;
         pair_c_pin_n <= 1'b1;
      end else begin
         pair_b_pin_p <= pair_lvl[0];
         pair_b_pin_n <= !pair_lvl[0];
         pair_c_pin_p <= pair_lvl[1];
         pair_c_pin_n <= !pair_lvl[1];
      end
   end

endmodule

/* File: test/output_pair_clock_divider_assertions.sv */
/* Port checker for the output-pair clock divider.
   Assumes it is bound to the top module and shares its APB clock and reset. */
`timescale 1ns/1ps
module output_pair_clock_divider_assertions (
   input wire logic                                   pclk,
   input wire logic                                   presetn,
   input wire logic                                   psel,
   input wire logic                                   penable,
   input wire logic                                   pwrite,
   input wire logic [clock_divider_pkg::ADDR_W-1:0]   paddr,
   input wire logic [clock_divider_pkg::DATA_W-1:0]   prdata,
   input wire logic                                   pready,
   input wire logic                                   pslverr,
   input wire logic                                   pair_b_pin_p,
   input wire logic                                   pair_b_pin_n,
   input wire logic                                   pair_c_pin_p,
   input wire logic                                   pair_c_pin_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================================
   // Assertions
   // ==========================================================================
   // Pair b polarity.
   pair_b_inv_a: assert property (pair_b_pin_n == !pair_b_pin_p)
      else $error("pair b legs not complementary");
   pair_c_inv_a: assert property (pair_c_pin_n == !pair_c_pin_p)
      else $error("pair c legs not complementary");
   access_ready_a: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error flag outside access phase");
   upper_zero_a: assert property (prdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   bad_addr_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("misaligned access not refused");
   err_read_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h00000000)
      else $error("refused read returned data");
   rd_hold_a: assert property (psel && penable && !pwrite |=> $stable(prdata))
      else $error("read data changed after access");
   // ==========================================================================
   // Cover
   // ==========================================================================
   cover property (psel && penable && pslverr);
   cover property ($rose(pair_b_pin_p) ##[1:40] $fell(pair_b_pin_p));
   cover property ($rose(pair_c_pin_p) ##[1:40] $fell(pair_c_pin_p));
endmodule

/* File: test/output_pair_clock_divider_bench.sv */
/* Self-checking bench for the output-pair clock divider.
   Assumes the design package is compiled first and the checker is present. */
`timescale 1ns/1ps
module output_pair_clock_divider_bench;
   logic                                 pclk, presetn, psel, penable, pwrite;
   logic                                 osc_level, ext_level, sync_n, ext_tog;
   logic [clock_divider_pkg::ADDR_W-1:0] paddr;
   logic [31:0]                          pwdata, prdata, rd;
   logic [3:0]                           pstrb;
   logic                                 pready, pslverr, err, b_p, b_n, c_p, c_n;
   logic [7:0]                           model [int];
   logic [9:0]                           regs_l [7];
   int                                   err_count, n_tests, hi, lo, l, h, seed;

   output_pair_clock_divider u_output_pair_clock_divider (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .osc_level(osc_level), .ext_level(ext_level), .sync_n(sync_n),
      .pair_b_pin_p(b_p), .pair_b_pin_n(b_n), .pair_c_pin_p(c_p), .pair_c_pin_n(c_n));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (ext_tog) ext_level <= ~ext_level;
   end
   // ==========================================================================
   // Helpers
   // ==========================================================================
   function automatic int nxt();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic pin(input int ch);
      return (ch == 1) ? c_p : b_p;
   endfunction
   function automatic logic [9:0] ridx(input int ch, input int k);
      return (ch == 1) ? clock_divider_pkg::IDX_C_COUNTS + 10'(k)
                       : clock_divider_pkg::IDX_B_COUNTS + 10'(k);
   endfunction
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [9:0] idx, input logic [7:0] v);
      apb(1'b1, {idx, 2'h0}, {24'h000000, v});
      model[idx] = (idx == clock_divider_pkg::IDX_B_ROUTE || idx == clock_divider_pkg::IDX_C_ROUTE
                    || idx == clock_divider_pkg::IDX_CLK_INPUT) ? (v & 8'h03) : v;
   endtask
   task automatic rdc(input logic [9:0] idx);
      apb(1'b0, {idx, 2'h0}, 32'h00000000);
      chk(rd, {24'h000000, model[idx]});
   endtask
   task automatic wait_lvl(input int ch, input logic v);
      int n;
      n = 0;
      while (pin(ch) !== v) begin
         @(posedge pclk);
         n++;
         if (n > 300) begin
            err_count++;
            finish_test();
         end
      end
   endtask
   task automatic measure(input int ch);
      wait_lvl(ch, 1'b0);
      wait_lvl(ch, 1'b1);
      hi = 0;
      while (pin(ch) === 1'b1 && hi < 300) begin
         @(posedge pclk);
         hi++;
      end
      lo = 0;
      while (pin(ch) === 1'b0 && lo < 300) begin
         @(posedge pclk);
         lo++;
      end
   endtask
   // ==========================================================================
   // Sequence
   // ==========================================================================
   initial begin
      {presetn, psel, penable, pwrite, osc_level, ext_level, ext_tog} = 7'h00;
      sync_n = 1'b1;
      pstrb = 4'hF;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      err_count = 0;
      n_tests = 0;
      seed = 82659;
      regs_l = '{clock_divider_pkg::IDX_B_COUNTS, clock_divider_pkg::IDX_B_CONTROL,
                 clock_divider_pkg::IDX_B_ROUTE, clock_divider_pkg::IDX_C_COUNTS,
                 clock_divider_pkg::IDX_C_CONTROL, clock_divider_pkg::IDX_C_ROUTE,
                 clock_divider_pkg::IDX_CLK_INPUT};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 7; i++) begin
         model[regs_l[i]] = 8'h00;
         rdc(regs_l[i]);
      end
      for (int i = 0; i < 6; i++) begin
         wr(regs_l[i], 8'(nxt()));
         rdc(regs_l[i]);
      end
      pstrb <= 4'h0;
      apb(1'b1, {clock_divider_pkg::IDX_C_COUNTS, 2'h0}, 32'h000000A5);
      pstrb <= 4'hF;
      rdc(clock_divider_pkg::IDX_C_COUNTS);
      apb(1'b0, 12'h400, 32'h00000000);
      chk({rd[30:0], err}, 32'h00000001);
      apb(1'b1, {clock_divider_pkg::IDX_C_COUNTS, 2'h2}, 32'h000000FF);
      chk(err, 1'b1);
      rdc(clock_divider_pkg::IDX_C_COUNTS);
      wr(clock_divider_pkg::IDX_CLK_INPUT, 8'h01);
      ext_tog <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         l = nxt() & 15;
         h = nxt() & 15;
         wr(ridx(k / 2, 0), {4'(l), 4'(h)});
         wr(ridx(k / 2, 1), 8'h40);
         wr(ridx(k / 2, 2), 8'(k % 2));
         measure(k / 2);
         measure(k / 2);
         chk(hi, (k % 2) ? 2 * (h + 1) : l + h + 2);
         chk(lo, (k % 2) ? 2 * (l + 1) : l + h + 2);
      end
      wr(ridx(1, 1), 8'hC0);
      measure(1);
      chk({hi[15:0], lo[15:0]}, 32'h00010001);
      wr(ridx(1, 1), 8'h60);
      repeat (4) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         @(posedge pclk);
         chk(c_p, 1'b1);
      end
      wr(ridx(1, 1), 8'h00);
      sync_n <= 1'b0;
      repeat (6) @(posedge pclk);
      chk(c_p, 1'b0);
      wr(ridx(0, 0), {4'(l), 4'(h)});
      wr(ridx(0, 2), 8'h00);
      measure(0);
      chk(hi, 32'(l + h + 2));
      wr(ridx(1, 0), 8'h01);
      wr(ridx(1, 2), 8'h01);
      wr(ridx(1, 1), 8'h13);
      chk(c_p, 1'b0);
      sync_n <= 1'b1;
      wait_lvl(1, 1'b1);
      measure(1);
      chk({hi[15:0], lo[15:0]}, 32'h00040002);
      for (int ch = 0; ch < 2; ch++) begin
         wr(ridx(ch, 1), 8'h40);
         wr(ridx(ch, 0), 8'h00);
         wr(ridx(ch, 2), 8'h02);
         ext_tog <= 1'b0;
         for (int s = 0; s < 4; s++) begin
            if (s % 2 == 0) wr(clock_divider_pkg::IDX_CLK_INPUT, (s < 2) ? 8'h02 : 8'h00);
            if (s < 2) osc_level <= s[0];
            else ext_level <= s[0];
            repeat (4) @(posedge pclk);
            chk(pin(ch), s[0]);
         end
         osc_level <= 1'b1;
         ext_tog <= 1'b1;
         wr(clock_divider_pkg::IDX_CLK_INPUT, 8'h01);
         measure(ch);
         chk({hi[15:0], lo[15:0]}, 32'h00020002);
      end
      finish_test();
   end
endmodule

bind output_pair_clock_divider output_pair_clock_divider_assertions u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pair_b_pin_p(pair_b_pin_p), .pair_b_pin_n(pair_b_pin_n),
   .pair_c_pin_p(pair_c_pin_p), .pair_c_pin_n(pair_c_pin_n));
